/* include/fpectl_pkg.sv */
// Purpose: constants and types for the flash program/erase control block
// Assumes: 16-bit register port, 24-bit program address space
// Notes:   offsets are word indices on the plain register port
// What this block does
// R1: start bit launches operation, hardware clears it
// R2: start bit is set-only by software
// R3: permit bit zero inhibits program and erase
// R4: bad start attempt sets sequence fault flag
// R5: erase bit picks erase or program action
// R6: codes 011000/01/10 erase one/two/four rows
// R7: row erases use table pointer address
// R8: boot and full erase only in serial mode
// R9: config, eeprom and general block erases
// R10: code 0001xx programs one flash row
// R11: unassigned operation codes do nothing
// R12: program-only select affects only eeprom writes
// R13: data eeprom is 256 words of 16 bits
// R14: data eeprom starts at word address 7FFE00
// R15: table reads and writes serve data eeprom
// R16: locations are 24 bits, phantom byte reads zero
// R17: lower word even, counter steps by two
// R18: reset fetch at 000000, vectors below 000200
// R19: two vector tables at 000004 and 000104
// R20: seven configuration words at fixed addresses
// R21: control bits 11 to 7 read zero
// R22: busy operation ignores start and command changes
package fpectl_pkg;
	localparam logic [2:0]  REG_CTRL         = 3'h0;
	localparam logic [2:0]  REG_PTR_LO       = 3'h1;
	localparam logic [2:0]  REG_PTR_HI       = 3'h2;
	localparam logic [2:0]  REG_DAT_LO       = 3'h3;
	localparam logic [2:0]  REG_DAT_HI       = 3'h4;
	localparam logic [2:0]  REG_TBL_CMD      = 3'h5;
	localparam logic [2:0]  REG_STATUS       = 3'h6;
	localparam int          CTRL_START_BIT   = 15;
	localparam int          CTRL_PERMIT_BIT  = 14;
	localparam int          CTRL_FAULT_BIT   = 13;
	localparam int          CTRL_NOERASE_BIT = 12;
	localparam int          CTRL_ERASE_BIT   = 6;
	localparam int          TBL_READ_BIT     = 0;
	localparam logic [5:0]  OP_ROW1          = 6'h18;
	localparam logic [5:0]  OP_ROW2          = 6'h19;
	localparam logic [5:0]  OP_ROW4          = 6'h1a;
	localparam logic [3:0]  OP_BOOT_PFX      = 4'ha;
	localparam logic [3:0]  OP_ALL_PFX       = 4'h9;
	localparam logic [3:0]  OP_CFG_PFX       = 4'h5;
	localparam logic [3:0]  OP_EE_PFX        = 4'h4;
	localparam logic [3:0]  OP_GEN_PFX       = 4'h3;
	localparam logic [3:0]  OP_PROG_PFX      = 4'h1;
	localparam int          EE_WORDS         = 256;
	localparam int          EE_DW            = 16;
	localparam logic [23:0] EE_BASE          = 24'h7ffe00;
	localparam logic [7:0]  EE_LAST          = 8'hff;
	localparam logic [15:0] EE_ERASED        = 16'hffff;
	localparam logic [23:0] RESET_VEC        = 24'h000000;
	localparam logic [23:0] START_VEC        = 24'h000002;
	localparam logic [23:0] VEC_END          = 24'h000200;
	localparam logic [23:0] PRI_VEC_BASE     = 24'h000004;
	localparam logic [23:0] ALT_VEC_BASE     = 24'h000104;
	localparam logic [6:0]  VEC_ENTRIES      = 7'd126;
	localparam logic [23:0] PC_STEP          = 24'h000002;
	localparam logic [23:0] CFG_BOOT_ADDR    = 24'hf80000;
	localparam logic [23:0] CFG_GSEG_ADDR    = 24'hf80004;
	localparam logic [23:0] CFG_OSEL_ADDR    = 24'hf80006;
	localparam logic [23:0] CFG_OSC_ADDR     = 24'hf80008;
	localparam logic [23:0] CFG_WDOG_ADDR    = 24'hf8000a;
	localparam logic [23:0] CFG_POR_ADDR     = 24'hf8000c;
	localparam logic [23:0] CFG_DBG_ADDR     = 24'hf8000e;
	localparam logic [7:0]  CFG_ERASED       = 8'hff;
	localparam logic [7:0]  CFG_CP_MASK      = 8'h01;
	localparam int          OP_CYCLES_DEF    = 64;

	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_READ  = 2'b01,
		S_WAIT  = 2'b11,
		S_SWEEP = 2'b10
	} fpectl_state_t;

	typedef enum logic [2:0] {
		ACT_NONE, ACT_ROWS, ACT_BOOT, ACT_ALL, ACT_CFG, ACT_EE, ACT_GEN, ACT_PROG
	} fpectl_act_t;
endpackage

/* core/fpectl_mem.sv */
// Purpose: data eeprom storage, one port, registered read data
// Assumes: read and write never in the same cycle
// Notes:   contents are not cleared by reset, as in a real array
`timescale 1ns/1ps
module fpectl_mem #(
	parameter int DW    = 16,
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic          mclk_i,
	input  wire logic          rst_n_i,
	input  wire logic          rd_i,
	input  wire logic          wr_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	output logic      [DW-1:0] rdata_o
);
	if (DEPTH != (1 << AW))
	begin : g_chk
		$error("fpectl_mem: depth must equal two to the address width");
	end

	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge mclk_i)
	begin
		if (wr_i)
			mem[addr_i] <= wdata_i;
		if (!rst_n_i)
			rdata_o <= '0;
		else if (rd_i)
			rdata_o <= mem[addr_i];
	end
endmodule

/* core/fpectl_timer.sv */
// Purpose: self-timing counter for program and erase operations
// Assumes: start is a one-cycle pulse
// Notes:   done pulses once, cycles_i edges after the start edge
`timescale 1ns/1ps
module fpectl_timer #(
	parameter int CNT_W = 16
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire logic             start_i,
	input  wire logic [CNT_W-1:0] cycles_i,
	output logic                  done_o
);
	typedef struct packed {
		logic             run;
		logic [CNT_W-1:0] cnt;
		logic             done;
	} fpectl_tmr_t;

	fpectl_tmr_t st_ff;
	fpectl_tmr_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (start_i)
		begin
			nxt_st.run = 1'b1;
			nxt_st.cnt = cycles_i;
		end
		else if (st_ff.run)
		begin
			if (st_ff.cnt <= CNT_W'(1))
			begin
				nxt_st.run = 1'b0;
				nxt_st.done = 1'b1;
			end
			else
				nxt_st.cnt = st_ff.cnt - CNT_W'(1);
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign done_o = st_ff.done;
endmodule

/* core/fpectl_ctrl.sv */
// Purpose: nonvolatile control register, program/erase sequencer,
//          data eeprom, configuration words and fetch address
// Assumes: register strobes one cycle, never both at once
// Notes:   flash rows live in an external array behind array_*_o
`timescale 1ns/1ps
module fpectl_ctrl
	import fpectl_pkg::*;
#(
	parameter int OP_CYCLES = OP_CYCLES_DEF,
	parameter int TMR_W     = 16
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [2:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [15:0] reg_rdata_o,
	input  wire logic        serial_prog_mode_i,
	input  wire logic [23:0] array_rdata_i,
	output logic             array_busy_o,
	output logic             array_erase_o,
	output logic      [5:0]  array_cmd_o,
	output logic      [23:0] array_addr_o,
	output logic      [2:0]  array_rows_o,
	output logic             array_rd_o,
	output logic      [23:0] array_wdata_o,
	input  wire logic        fetch_step_i,
	input  wire logic        vec_take_i,
	input  wire logic [6:0]  vec_num_i,
	input  wire logic        vec_alt_i,
	output logic      [23:0] fetch_addr_o
);
	if (OP_CYCLES < 1 || OP_CYCLES >= (1 << TMR_W))
	begin : g_chk
		$error("fpectl_ctrl: OP_CYCLES does not fit the timer");
	end

	typedef struct packed {
		logic               start;
		logic               permit;
		logic               fault;
		logic               prog_only;
		logic               erase;
		logic [5:0]         opcode;
		logic [23:0]        ptr;
		logic [23:0]        latch;
		fpectl_state_t      state;
		fpectl_act_t        act;
		logic [7:0]         sweep_idx;
		logic [6:0][7:0]    cfg;
		logic               tr_ee;
		logic               tr_arr;
		logic [15:0]        rdata;
		logic               arr_busy;
		logic               arr_erase;
		logic [5:0]         arr_cmd;
		logic [23:0]        arr_addr;
		logic [2:0]         arr_rows;
		logic               arr_rd;
		logic [23:0]        pc;
	} fpectl_st_t;

	fpectl_st_t    st_ff;
	fpectl_st_t    nxt_st;
	logic          mem_rd;
	logic          mem_wr;
	logic [7:0]    mem_addr;
	logic [15:0]   mem_wdata;
	logic [15:0]   mem_rdata;
	logic          tmr_start;
	logic          tmr_done;

	// operation code to action; full-chip and boot erases need serial mode
	function automatic fpectl_act_t op_decode(input logic er, input logic [5:0] op,
		input logic ser);
		fpectl_act_t a;
		a = ACT_NONE;
		if (er)
		begin
			if (op == OP_ROW1 || op == OP_ROW2 || op == OP_ROW4)
				a = ACT_ROWS; // R6
			else if (op[5:2] == OP_BOOT_PFX)
				a = ser ? ACT_BOOT : ACT_NONE; // R8
			else if (op[5:2] == OP_ALL_PFX)
				a = ser ? ACT_ALL : ACT_NONE; // R8
			else if (op[5:2] == OP_CFG_PFX)
				a = ACT_CFG; // R9
			else if (op[5:2] == OP_EE_PFX)
				a = ACT_EE; // R9
			else if (op[5:2] == OP_GEN_PFX)
				a = ACT_GEN; // R9
		end
		else if (op[5:2] == OP_PROG_PFX)
			a = ACT_PROG; // R10
		return a; // R11
	endfunction

	// data eeprom window: 256 words from 7ffe00, lower words on even addresses
	function automatic logic ee_hit(input logic [23:0] addr);
		return addr[23:9] == EE_BASE[23:9]; // R14
	endfunction

	// configuration word lookup: {hit, index}
	function automatic logic [3:0] cfg_index(input logic [23:0] addr);
		logic [3:0] r;
		r = 4'h0;
		unique case (addr) // R20
			CFG_BOOT_ADDR: r = 4'h8;
			CFG_GSEG_ADDR: r = 4'h9;
			CFG_OSEL_ADDR: r = 4'ha;
			CFG_OSC_ADDR:  r = 4'hb;
			CFG_WDOG_ADDR: r = 4'hc;
			CFG_POR_ADDR:  r = 4'hd;
			CFG_DBG_ADDR:  r = 4'he;
			default:       r = 4'h0;
		endcase
		return r;
	endfunction

	fpectl_mem #(
		.DW    (EE_DW),
		.DEPTH (EE_WORDS),
		.AW    (8)
	) i_fpectl_mem (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.rd_i    (mem_rd),
		.wr_i    (mem_wr),
		.addr_i  (mem_addr),
		.wdata_i (mem_wdata),
		.rdata_o (mem_rdata)
	);

	fpectl_timer #(
		.CNT_W (TMR_W)
	) i_fpectl_timer (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.start_i  (tmr_start),
		.cycles_i (TMR_W'(OP_CYCLES)),
		.done_o   (tmr_done)
	);

	always_comb
	begin
		fpectl_act_t act_new;
		logic [3:0]  ci;
		act_new = ACT_NONE;
		ci = cfg_index(st_ff.ptr);
		nxt_st = st_ff;
		nxt_st.arr_rd = 1'b0;
		nxt_st.rdata = 16'h0000;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		mem_addr = st_ff.ptr[8:1]; // R17
		mem_wdata = EE_ERASED;

		// table read completions land in the data latch
		if (st_ff.tr_ee)
		begin
			nxt_st.latch = {8'h00, mem_rdata}; // R15
			nxt_st.tr_ee = 1'b0;
		end
		if (st_ff.tr_arr)
		begin
			nxt_st.latch = array_rdata_i;
			nxt_st.tr_arr = 1'b0;
		end

		unique case (st_ff.state)
			S_IDLE: ;
			S_READ:
			begin
				// program-only skips the implied erase: bits can only clear
				mem_wr = 1'b1;
				mem_wdata = st_ff.prog_only ? (mem_rdata & st_ff.latch[15:0])
					: st_ff.latch[15:0]; // R12
				nxt_st.state = S_WAIT;
			end
			S_SWEEP:
			begin
				mem_wr = 1'b1;
				mem_addr = st_ff.sweep_idx;
				nxt_st.sweep_idx = st_ff.sweep_idx + 8'h01;
				if (st_ff.sweep_idx == EE_LAST) // R13
					nxt_st.state = S_WAIT;
			end
			S_WAIT:
			begin
				if (tmr_done)
				begin
					nxt_st.start = 1'b0; // R1
					nxt_st.arr_busy = 1'b0;
					nxt_st.arr_rows = 3'h0;
					nxt_st.act = ACT_NONE;
					nxt_st.state = S_IDLE;
				end
			end
		endcase

		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				REG_CTRL:
				begin
					nxt_st.permit = reg_wdata_i[CTRL_PERMIT_BIT];
					nxt_st.fault = reg_wdata_i[CTRL_FAULT_BIT];
					nxt_st.prog_only = reg_wdata_i[CTRL_NOERASE_BIT];
					if (!st_ff.start)
					begin
						nxt_st.erase = reg_wdata_i[CTRL_ERASE_BIT]; // R22
						nxt_st.opcode = reg_wdata_i[5:0]; // R22
					end
					if (reg_wdata_i[CTRL_START_BIT]) // R2
					begin
						if (st_ff.start || !st_ff.permit)
							nxt_st.fault = 1'b1; // R3 R4 R22
						else
							act_new = op_decode(reg_wdata_i[CTRL_ERASE_BIT],
								reg_wdata_i[5:0], serial_prog_mode_i); // R5
					end
				end
				REG_PTR_LO:
					if (!st_ff.start)
						nxt_st.ptr[15:0] = reg_wdata_i;
				REG_PTR_HI:
					if (!st_ff.start)
						nxt_st.ptr[23:16] = reg_wdata_i[7:0];
				REG_DAT_LO:
					if (!st_ff.start)
						nxt_st.latch[15:0] = reg_wdata_i;
				REG_DAT_HI:
					if (!st_ff.start)
						nxt_st.latch[23:16] = reg_wdata_i[7:0];
				REG_TBL_CMD:
				begin
					// table read; the eeprom port belongs to the sequencer when busy
					if (reg_wdata_i[TBL_READ_BIT] && !st_ff.start && !st_ff.tr_arr)
					begin
						if (ee_hit(st_ff.ptr))
						begin
							mem_rd = 1'b1; // R15
							nxt_st.tr_ee = 1'b1;
						end
						else if (ci[3])
							nxt_st.latch = {16'h0000, st_ff.cfg[ci[2:0]]};
						else
						begin
							nxt_st.arr_rd = 1'b1;
							nxt_st.tr_arr = 1'b1;
						end
					end
				end
				default: ;
			endcase
		end

		// launch of a recognised operation
		if (act_new != ACT_NONE)
		begin
			nxt_st.start = 1'b1; // R1
			nxt_st.act = act_new;
			nxt_st.arr_addr = st_ff.ptr; // R7
			nxt_st.arr_cmd = reg_wdata_i[5:0];
			nxt_st.arr_erase = reg_wdata_i[CTRL_ERASE_BIT];
			nxt_st.state = S_WAIT;
			unique case (act_new)
				ACT_ROWS:
				begin
					nxt_st.arr_busy = 1'b1;
					nxt_st.arr_rows = (reg_wdata_i[5:0] == OP_ROW1) ? 3'h1
						: (reg_wdata_i[5:0] == OP_ROW2) ? 3'h2 : 3'h4; // R6
				end
				ACT_BOOT, ACT_GEN:
					nxt_st.arr_busy = 1'b1;
				ACT_CFG:
					for (int i = 0; i < 7; i++)
						nxt_st.cfg[i] = (st_ff.cfg[i] & CFG_CP_MASK)
							| (CFG_ERASED & ~CFG_CP_MASK); // R9
				ACT_EE:
				begin
					nxt_st.sweep_idx = 8'h00; // R9
					nxt_st.state = S_SWEEP;
				end
				ACT_ALL:
				begin
					for (int i = 0; i < 7; i++)
						nxt_st.cfg[i] = CFG_ERASED; // R8
					nxt_st.arr_busy = 1'b1;
					nxt_st.sweep_idx = 8'h00;
					nxt_st.state = S_SWEEP;
				end
				ACT_PROG:
				begin
					if (ee_hit(st_ff.ptr))
					begin
						mem_rd = 1'b1; // R15
						nxt_st.state = S_READ;
					end
					else if (ci[3])
						nxt_st.cfg[ci[2:0]] = st_ff.latch[7:0]; // R20
					else
						nxt_st.arr_busy = 1'b1; // R10
				end
				default: ;
			endcase
		end
		tmr_start = (nxt_st.state == S_WAIT) && (st_ff.state != S_WAIT);

		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				REG_CTRL:
					nxt_st.rdata = {st_ff.start, st_ff.permit, st_ff.fault, st_ff.prog_only,
						5'h00, st_ff.erase, st_ff.opcode}; // R21
				REG_PTR_LO:  nxt_st.rdata = st_ff.ptr[15:0];
				REG_PTR_HI:  nxt_st.rdata = {8'h00, st_ff.ptr[23:16]};
				REG_DAT_LO:  nxt_st.rdata = st_ff.latch[15:0];
				REG_DAT_HI:  nxt_st.rdata = {8'h00, st_ff.latch[23:16]}; // R16
				REG_TBL_CMD: nxt_st.rdata = {15'h0000, st_ff.tr_ee | st_ff.tr_arr};
				REG_STATUS:
					nxt_st.rdata = {11'h000, st_ff.arr_busy, serial_prog_mode_i,
						st_ff.start, st_ff.state};
				default:     nxt_st.rdata = 16'h0000;
			endcase
		end

		// fetch address: reset at the reset vector, step by two, vector loads
		if (vec_take_i && vec_num_i < VEC_ENTRIES)
			nxt_st.pc = (vec_alt_i ? ALT_VEC_BASE : PRI_VEC_BASE)
				+ {16'h0000, vec_num_i, 1'b0}; // R19
		else if (fetch_step_i)
			nxt_st.pc = st_ff.pc + PC_STEP; // R17
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			st_ff <= '0;
			st_ff.state <= S_IDLE;
			st_ff.act <= ACT_NONE;
			st_ff.cfg <= {7{CFG_ERASED}};
			st_ff.pc <= RESET_VEC; // R18
		end
		else
			st_ff <= nxt_st;
	end

	assign reg_rdata_o = st_ff.rdata;
	assign array_busy_o = st_ff.arr_busy;
	assign array_erase_o = st_ff.arr_erase;
	assign array_cmd_o = st_ff.arr_cmd;
	assign array_addr_o = st_ff.arr_addr;
	assign array_rows_o = st_ff.arr_rows;
	assign array_rd_o = st_ff.arr_rd;
	assign array_wdata_o = st_ff.latch;
	assign fetch_addr_o = st_ff.pc;
endmodule

/* testbench/fpectl_chk.sv */
// Purpose: port checker for the program/erase control block
// Assumes: OP_CYCLES of at least 4
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
module fpectl_chk
	import fpectl_pkg::*;
#(
	parameter int OP_CYCLES = OP_CYCLES_DEF
) (
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	input wire logic [2:0]  reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        array_busy_o,
	input wire logic        array_erase_o,
	input wire logic [5:0]  array_cmd_o,
	input wire logic [2:0]  array_rows_o,
	input wire logic        array_rd_o,
	input wire logic        fetch_step_i,
	input wire logic        vec_take_i,
	input wire logic [6:0]  vec_num_i,
	input wire logic        vec_alt_i,
	input wire logic [23:0] fetch_addr_o
);
	localparam int BUSY_MAX = OP_CYCLES + 300;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	property p_rsv;
		reg_rd_i && reg_addr_i == REG_CTRL |=> reg_rdata_o[11:7] == 5'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
	property p_lock;
		reg_wr_i && reg_addr_i == REG_CTRL && array_busy_o
			|=> $stable(array_cmd_o) && $stable(array_erase_o);
	endproperty
	a_lock: assert property (p_lock) else $error("command changed while busy");
	property p_rowset;
		array_rows_o != 3'h0 |-> array_erase_o && array_rows_o ==
			(array_cmd_o == OP_ROW1 ? 3'h1 : (array_cmd_o == OP_ROW2 ? 3'h2 : 3'h4));
	endproperty
	a_rowset: assert property (p_rowset) else $error("row count mismatch");
	property p_busy;
		$rose(array_busy_o) |-> array_busy_o [*4] ##[1:BUSY_MAX] !array_busy_o;
	endproperty
	a_busy: assert property (p_busy) else $error("busy length wrong");
	property p_rowclr;
		$fell(array_busy_o) |-> array_rows_o == 3'h0;
	endproperty
	a_rowclr: assert property (p_rowclr) else $error("rows kept after done");
	property p_step;
		fetch_step_i && !vec_take_i |=> fetch_addr_o == $past(fetch_addr_o) + PC_STEP;
	endproperty
	a_step: assert property (p_step) else $error("fetch step wrong");
	property p_vec;
		vec_take_i && vec_num_i < VEC_ENTRIES |=> fetch_addr_o ==
			($past(vec_alt_i) ? ALT_VEC_BASE : PRI_VEC_BASE) + {16'h0, $past(vec_num_i), 1'b0};
	endproperty
	a_vec: assert property (p_vec) else $error("vector address wrong");
	property p_rdpulse;
		array_rd_o |=> !array_rd_o;
	endproperty
	a_rdpulse: assert property (p_rdpulse) else $error("array read not a pulse");
endmodule

bind fpectl_ctrl fpectl_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (
	.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.array_busy_o(array_busy_o), .array_erase_o(array_erase_o),
	.array_cmd_o(array_cmd_o), .array_rows_o(array_rows_o), .array_rd_o(array_rd_o),
	.fetch_step_i(fetch_step_i), .vec_take_i(vec_take_i), .vec_num_i(vec_num_i),
	.vec_alt_i(vec_alt_i), .fetch_addr_o(fetch_addr_o));

/* testbench/fpectl_ctrl_bench.sv */
// Purpose: self-checking bench for the program/erase control block
// Assumes: OP_CYCLES shortened to 16
// Notes:   register port driven by tasks, one strobe per cycle
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module fpectl_ctrl_bench;
	import fpectl_pkg::*;
	logic        mclk_i             = 1'b0;
	logic        rst_n_i            = 1'b0;
	logic [2:0]  reg_addr_i         = 3'h0;
	logic [15:0] reg_wdata_i        = 16'h0;
	logic        reg_wr_i           = 1'b0;
	logic        reg_rd_i           = 1'b0;
	logic        serial_prog_mode_i = 1'b0;
	logic [23:0] array_rdata_i      = 24'h3c5a69;
	logic        fetch_step_i       = 1'b0;
	logic        vec_take_i         = 1'b0;
	logic [6:0]  vec_num_i          = 7'h0;
	logic        vec_alt_i          = 1'b0;
	logic [15:0] reg_rdata_o;
	logic        array_busy_o;
	logic        array_erase_o;
	logic [5:0]  array_cmd_o;
	logic [23:0] array_addr_o;
	logic [2:0]  array_rows_o;
	logic        array_rd_o;
	logic [23:0] array_wdata_o;
	logic [23:0] fetch_addr_o;
	logic [15:0] d;
	logic [5:0]  ops [5] = '{6'h28, 6'h24, 6'h14, 6'h10, 6'h0c};
	int          fails              = 0;
	int          checks             = 0;

	fpectl_ctrl #(.OP_CYCLES(16)) i_fpectl_ctrl (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .serial_prog_mode_i(serial_prog_mode_i),
		.array_rdata_i(array_rdata_i), .array_busy_o(array_busy_o),
		.array_erase_o(array_erase_o), .array_cmd_o(array_cmd_o),
		.array_addr_o(array_addr_o), .array_rows_o(array_rows_o), .array_rd_o(array_rd_o),
		.array_wdata_o(array_wdata_o),
		.fetch_step_i(fetch_step_i), .vec_take_i(vec_take_i),
		.vec_num_i(vec_num_i), .vec_alt_i(vec_alt_i), .fetch_addr_o(fetch_addr_o));

	always #20 mclk_i = ~mclk_i;

	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
		begin
			$display("Run complete: PASS");
		end
		else
		begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] v);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] v);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		v = reg_rdata_o;
	endtask

	task automatic chk_rd(input logic [2:0] a, input logic [15:0] e);
		rd(a, d);
		`CHK(d, e)
	endtask

	// poll the start bit until hardware clears it
	task automatic wait_idle;
		for (int n = 0; n < 300; n++)
		begin
			rd(REG_CTRL, d);
			if (d[CTRL_START_BIT] === 1'b0)
				return;
		end
		fails++;
		test_done;
	endtask

	task automatic tbl_rd;
		wr(REG_TBL_CMD, 16'h0001);
		repeat (2) @(posedge mclk_i);
	endtask

	initial
	begin
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		chk_rd(REG_CTRL, 16'h0000);
		`CHK(fetch_addr_o, RESET_VEC)
		wr(REG_CTRL, 16'h8058);
		chk_rd(REG_CTRL, 16'h2058);
		`CHK(array_busy_o, 1'b0)
		wr(REG_CTRL, 16'h4f80);
		chk_rd(REG_CTRL, 16'h4000);
		wr(REG_PTR_LO, 16'h1234);
		wr(REG_PTR_HI, 16'h0056);
		for (int i = 0; i < 3; i++)
		begin
			wr(REG_CTRL, 16'hc058 + 16'(i));
			`CHK(array_rows_o, 3'(1 << i))
			`CHK(array_addr_o, 24'h561234)
			wait_idle;
			chk_rd(REG_CTRL, 16'h4058 + 16'(i));
			`CHK(array_rows_o, 3'h0)
		end
		wr(REG_CTRL, 16'hc05a);
		wr(REG_CTRL, 16'h4058);
		wr(REG_CTRL, 16'hc058);
		chk_rd(REG_CTRL, 16'he05a);
		chk_rd(REG_STATUS, 16'h0017);
		`CHK(array_cmd_o, OP_ROW4)
		wait_idle;
		wr(REG_CTRL, 16'hc07f);
		chk_rd(REG_CTRL, 16'h407f);
		wr(REG_CTRL, 16'hc068);
		chk_rd(REG_CTRL, 16'h4068);
		@(posedge mclk_i);
		serial_prog_mode_i <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			wr(REG_CTRL, 16'hc040 | 16'(ops[i]));
			wait_idle;
			`CHK(array_cmd_o, ops[i])
			`CHK(array_erase_o, 1'b1)
		end
		@(posedge mclk_i);
		serial_prog_mode_i <= 1'b0;
		wr(REG_PTR_LO, 16'hfffe);
		wr(REG_PTR_HI, 16'h007f);
		tbl_rd;
		chk_rd(REG_DAT_LO, EE_ERASED);
		wr(REG_DAT_LO, 16'ha5c3);
		`CHK(array_wdata_o, 24'h00a5c3)
		wr(REG_CTRL, 16'hc004);
		`CHK(array_busy_o, 1'b0)
		wait_idle;
		`CHK(array_erase_o, 1'b0)
		wr(REG_DAT_LO, 16'h0000);
		tbl_rd;
		chk_rd(REG_DAT_LO, 16'ha5c3);
		wr(REG_DAT_LO, 16'h0ff0);
		wr(REG_CTRL, 16'hd004);
		wait_idle;
		tbl_rd;
		chk_rd(REG_DAT_LO, 16'h05c0);
		wr(REG_PTR_LO, 16'h0100);
		wr(REG_PTR_HI, 16'h0000);
		wr(REG_TBL_CMD, 16'h0001);
		`CHK(array_rd_o, 1'b1)
		@(posedge mclk_i);
		#1;
		`CHK(array_rd_o, 1'b0)
		chk_rd(REG_DAT_LO, 16'h5a69);
		chk_rd(REG_DAT_HI, 16'h003c);
		@(posedge mclk_i);
		#1;
		`CHK(reg_rdata_o, 16'h0000)
		wr(REG_PTR_LO, 16'h0004);
		wr(REG_PTR_HI, 16'h00f8);
		wr(REG_DAT_LO, 16'h0012);
		wr(REG_CTRL, 16'hc004);
		wait_idle;
		wr(REG_DAT_LO, 16'h0000);
		tbl_rd;
		chk_rd(REG_DAT_LO, 16'h0012);
		wr(REG_CTRL, 16'hc054);
		wait_idle;
		tbl_rd;
		chk_rd(REG_DAT_LO, 16'h00fe);
		chk_rd(3'h7, 16'h0000);
		@(posedge mclk_i);
		fetch_step_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		fetch_step_i <= 1'b0;
		#1;
		`CHK(fetch_addr_o, 24'h000004)
		@(posedge mclk_i);
		vec_take_i <= 1'b1;
		vec_num_i <= 7'd5;
		vec_alt_i <= 1'b1;
		fetch_step_i <= 1'b1;
		@(posedge mclk_i);
		vec_take_i <= 1'b0;
		fetch_step_i <= 1'b0;
		#1;
		`CHK(fetch_addr_o, 24'h00010e)
		@(posedge mclk_i);
		vec_take_i <= 1'b1;
		vec_num_i <= 7'd126;
		fetch_step_i <= 1'b1;
		@(posedge mclk_i);
		vec_take_i <= 1'b0;
		fetch_step_i <= 1'b0;
		#1;
		`CHK(fetch_addr_o, 24'h000110)
		test_done;
	end
endmodule
